//--- rtl/goi_pkg.sv
// Shared constants and state types of the pin and occupancy block
package goi_pkg;

  // Number of general-purpose pins and width of a pin index
  localparam int unsigned GOI_PIN_COUNT  = 4;
  localparam int unsigned GOI_PIN_IDX_W  = 2;

  // Timing: one second expressed in clock cycles at 40 MHz
  localparam int unsigned GOI_CLK_PERIOD_NS = 25;
  localparam int unsigned GOI_SECOND_NS     = 1_000_000_000;
  localparam int unsigned GOI_SEC_CYCLES    =
    GOI_SECOND_NS / GOI_CLK_PERIOD_NS;
  localparam int unsigned GOI_PRESC_W       = 26;

  // Timed level request limits, in whole seconds
  localparam logic [7:0]  GOI_TIME_MIN_S = 8'h01;
  localparam logic [7:0]  GOI_TIME_MAX_S = 8'h78;
  localparam int unsigned GOI_SECS_W     = 7;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] GOI_OFS_DIR      = 6'h00;
  localparam logic [5:0] GOI_OFS_LEVEL    = 6'h04;
  localparam logic [5:0] GOI_OFS_TOGGLE   = 6'h08;
  localparam logic [5:0] GOI_OFS_TIMED    = 6'h0C;
  localparam logic [5:0] GOI_OFS_TSTAT    = 6'h10;
  localparam logic [5:0] GOI_OFS_OCC_CTRL = 6'h14;
  localparam logic [5:0] GOI_OFS_OCC_STAT = 6'h18;
  localparam logic [5:0] GOI_OFS_IRQ_STAT = 6'h1C;
  localparam logic [5:0] GOI_OFS_IRQ_MASK = 6'h20;
  localparam logic [5:0] GOI_OFS_PIN_IN   = 6'h24;

  // Field positions of the timed request word
  localparam int unsigned GOI_TIMED_IDX_LSB  = 0;
  localparam int unsigned GOI_TIMED_LVL_BIT  = 8;
  localparam int unsigned GOI_TIMED_SECS_LSB = 16;

  // Field positions of the occupancy registers
  localparam int unsigned GOI_OCC_POL_BIT      = 0;
  localparam int unsigned GOI_OCC_LEVEL_BIT    = 0;
  localparam int unsigned GOI_OCC_OCCUPIED_BIT = 1;

  // Interrupt status and mask bit positions
  localparam int unsigned GOI_IRQ_W       = 3;
  localparam int unsigned GOI_IRQ_EXPIRE  = 0;
  localparam int unsigned GOI_IRQ_REJECT  = 1;
  localparam int unsigned GOI_IRQ_OCC_CHG = 2;

  // Reset values
  localparam logic [GOI_PIN_COUNT-1:0] GOI_RST_DIR   = 4'h0;
  localparam logic [GOI_PIN_COUNT-1:0] GOI_RST_LEVEL = 4'h0;
  localparam logic                     GOI_RST_POL   = 1'b1;
  localparam logic [GOI_IRQ_W-1:0]     GOI_RST_MASK  = 3'h0;

  // State of one timed-level countdown
  typedef struct packed {
    logic                   active;
    logic                   expire;
    logic [GOI_SECS_W-1:0]  secs;
    logic [GOI_PRESC_W-1:0] presc;
  } goi_tmr_state_t;

  // State of the top block
  typedef struct packed {
    logic [GOI_PIN_COUNT-1:0] dir;
    logic [GOI_PIN_COUNT-1:0] level;
    logic [GOI_PIN_COUNT-1:0] saved;
    logic [GOI_PIN_COUNT-1:0] pinIn;
    logic                     pol;
    logic                     occLevel;
    logic                     occupied;
    logic [GOI_IRQ_W-1:0]     irqStat;
    logic [GOI_IRQ_W-1:0]     irqMask;
    logic                     irq;
    logic                     waitReq;
    logic [31:0]              rdata;
  } goi_state_t;

endpackage : goi_pkg

//--- rtl/goi_pin_timer.sv
// Per-pin countdown of whole seconds for timed output levels
`timescale 1ns/10ps
module goi_pin_timer
  import goi_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = GOI_SEC_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  load,
  input  wire logic [GOI_SECS_W-1:0] loadSecs,
  input  wire logic                  cancel,
  output logic                       active,
  output logic                       expire
);

  // Last prescaler value of one second
  localparam logic [GOI_PRESC_W-1:0] SecLast =
    GOI_PRESC_W'(SEC_CYCLES - 1);

  goi_tmr_state_t st_q;  // Registered state
  goi_tmr_state_t st_d;  // Next state

  // Own prescaler restarts on load, so every request gets whole seconds
  always_comb begin
    st_d        = st_q;
    st_d.expire = 1'b0;
    if (cancel) begin
      // Cancel beats load and expiry
      st_d.active = 1'b0;
    end else if (load) begin
      st_d.active = 1'b1;
      st_d.secs   = loadSecs;
      st_d.presc  = '0;
    end else if (st_q.active) begin
      if (st_q.presc == SecLast) begin
        // One second elapsed
        st_d.presc = '0;
        if (st_q.secs == GOI_SECS_W'(1)) begin
          st_d.active = 1'b0;
          st_d.expire = 1'b1;
        end else begin
          st_d.secs = st_q.secs - GOI_SECS_W'(1);
        end
      end else begin
        st_d.presc = st_q.presc + GOI_PRESC_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active = st_q.active;
  assign expire = st_q.expire;

endmodule : goi_pin_timer

//--- rtl/goi_top.sv
// General-purpose pins and occupancy input behind an Avalon-MM slave
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module goi_top
  import goi_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = GOI_SEC_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [5:0]               address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire logic [31:0]              writedata,
  input  wire logic [3:0]               byteenable,
  output logic [31:0]                   readdata,
  output logic                          waitrequest,
  input  wire logic [GOI_PIN_COUNT-1:0] gpioIn,
  output logic [GOI_PIN_COUNT-1:0]      gpioOut,
  output logic [GOI_PIN_COUNT-1:0]      gpioOe,
  input  wire logic                     occSenseIn,
  output logic                          occupied,
  output logic                          irq
);

  goi_state_t st_q;  // Registered state of the block
  goi_state_t st_d;  // Next state

  // Timer control, decoded in the same process as the state
  logic [GOI_PIN_COUNT-1:0] tmrLoad;    // Start a timed level
  logic [GOI_PIN_COUNT-1:0] tmrCancel;  // Abandon a timed level
  logic [GOI_SECS_W-1:0]    tmrSecs;    // Seconds for a new request
  logic [GOI_PIN_COUNT-1:0] tmrActive;  // Timed level in force
  logic [GOI_PIN_COUNT-1:0] tmrExpire;  // One-cycle end of a timed level

  // Bus handshake helpers
  logic        accept;     // Request seen, answer next cycle
  logic        commit;     // Request completes at this edge
  logic [31:0] wMask;      // Byte enables widened to bits
  logic [31:0] wData;      // Write data under the byte enables
  logic [31:0] rdMux;      // Read value selected by address

  // Timed request fields
  logic [GOI_PIN_IDX_W-1:0] reqIdx;   // Target pin
  logic                     reqLvl;   // Requested level
  logic [7:0]               reqSecs;  // Requested duration
  logic                     reqOk;    // Duration inside the legal range

  // Event pulses into the interrupt status
  logic [GOI_IRQ_W-1:0] events;   // Hardware set terms
  logic [GOI_IRQ_W-1:0] w1c;      // Software clear terms
  logic                 occNext;  // Occupancy seen by the next state

  // One countdown per pin; each keeps its own one-second prescaler
  for (genvar g = 0; g < GOI_PIN_COUNT; g++) begin : gTimer
    goi_pin_timer #(
      .SEC_CYCLES (SEC_CYCLES)
    ) uTimer (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (tmrLoad[g]),
      .loadSecs (tmrSecs),
      .cancel   (tmrCancel[g]),
      .active   (tmrActive[g]),
      .expire   (tmrExpire[g])
    );
  end

  // Byte lanes of the write data
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wMask[b*8 +: 8] = {8{byteenable[b]}};
    end
    wData = writedata & wMask;
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    if (address == GOI_OFS_DIR) begin
      rdMux[GOI_PIN_COUNT-1:0] = st_q.dir;
    end else if (address == GOI_OFS_LEVEL) begin
      rdMux[GOI_PIN_COUNT-1:0] = st_q.level;
    end else if (address == GOI_OFS_TSTAT) begin
      rdMux[GOI_PIN_COUNT-1:0] = tmrActive;
    end else if (address == GOI_OFS_OCC_CTRL) begin
      rdMux[GOI_OCC_POL_BIT] = st_q.pol;
    end else if (address == GOI_OFS_OCC_STAT) begin
      rdMux[GOI_OCC_LEVEL_BIT]    = st_q.occLevel;
      rdMux[GOI_OCC_OCCUPIED_BIT] = st_q.occupied;
    end else if (address == GOI_OFS_IRQ_STAT) begin
      rdMux[GOI_IRQ_W-1:0] = st_q.irqStat;
    end else if (address == GOI_OFS_IRQ_MASK) begin
      rdMux[GOI_IRQ_W-1:0] = st_q.irqMask;
    end else if (address == GOI_OFS_PIN_IN) begin
      rdMux[GOI_PIN_COUNT-1:0] = st_q.pinIn;
    end else begin
      // Toggle and timed request words are write-only
      rdMux = 32'h0000_0000;
    end
  end

  // Main next-state process
  always_comb begin
    st_d      = st_q;
    tmrLoad   = '0;
    tmrCancel = '0;
    events    = '0;
    w1c       = '0;

    // Timed request fields straight from the bus
    reqIdx  = wData[GOI_TIMED_IDX_LSB +: GOI_PIN_IDX_W];
    reqLvl  = wData[GOI_TIMED_LVL_BIT];
    reqSecs = wData[GOI_TIMED_SECS_LSB +: 8];
    reqOk   = (reqSecs >= GOI_TIME_MIN_S) &&
              (reqSecs <= GOI_TIME_MAX_S);
    tmrSecs = reqSecs[GOI_SECS_W-1:0];

    // Waitrequest is high when idle, low for the one completing cycle
    accept = (read || write) && st_q.waitReq;
    commit = (read || write) && !st_q.waitReq;
    st_d.waitReq = !accept;

    // Read data are taken a cycle early so they stand at the commit edge
    if (accept && read) begin
      st_d.rdata = rdMux;
    end

    // Pins and sensor are synchronous; one register stage for reading
    st_d.pinIn    = gpioIn;
    st_d.occLevel = occSenseIn;

    // Occupancy follows the sampled level and the polarity
    occNext       = (st_q.occLevel == st_q.pol);
    st_d.occupied = occNext;
    if (occNext != st_q.occupied) begin
      events[GOI_IRQ_OCC_CHG] = 1'b1;
    end

    // Expired timed levels fall back to the remembered level
    for (int i = 0; i < GOI_PIN_COUNT; i++) begin
      if (tmrExpire[i]) begin
        st_d.level[i] = st_q.saved[i];
      end
    end
    if (|tmrExpire) begin
      events[GOI_IRQ_EXPIRE] = 1'b1;
    end

    // Register writes take effect at the commit edge only
    if (commit && write) begin
      if (address == GOI_OFS_DIR) begin
        st_d.dir = (st_q.dir & ~wMask[GOI_PIN_COUNT-1:0]) |
                   wData[GOI_PIN_COUNT-1:0];
      end else if (address == GOI_OFS_LEVEL) begin
        for (int i = 0; i < GOI_PIN_COUNT; i++) begin
          if (wMask[i]) begin
            // A pin under a timed level keeps it; the write becomes
            // the level that returns when the time runs out
            if (tmrActive[i] && !tmrExpire[i]) begin
              st_d.saved[i] = wData[i];
            end else begin
              st_d.level[i] = wData[i];
            end
          end
        end
      end else if (address == GOI_OFS_TOGGLE) begin
        for (int i = 0; i < GOI_PIN_COUNT; i++) begin
          if (wData[i]) begin
            // Toggle ends any timed level so the result stays put
            st_d.level[i] = ~st_d.level[i];
            tmrCancel[i]  = 1'b1;
          end
        end
      end else if (address == GOI_OFS_TIMED) begin
        if (reqOk) begin
          // Remember the level only when no timed level is running,
          // so a retrigger still restores the original level
          if (!tmrActive[reqIdx] || tmrExpire[reqIdx]) begin
            st_d.saved[reqIdx] = st_d.level[reqIdx];
          end
          st_d.level[reqIdx] = reqLvl;
          tmrLoad[reqIdx]    = 1'b1;
        end else begin
          // Out-of-range duration: nothing changes, flag it
          events[GOI_IRQ_REJECT] = 1'b1;
        end
      end else if (address == GOI_OFS_OCC_CTRL) begin
        if (wMask[GOI_OCC_POL_BIT]) begin
          st_d.pol = wData[GOI_OCC_POL_BIT];
        end
      end else if (address == GOI_OFS_IRQ_STAT) begin
        w1c = wData[GOI_IRQ_W-1:0];
      end else if (address == GOI_OFS_IRQ_MASK) begin
        st_d.irqMask = (st_q.irqMask & ~wMask[GOI_IRQ_W-1:0]) |
                       wData[GOI_IRQ_W-1:0];
      end else begin
        // Unmapped or read-only address: write ignored
        st_d.dir = st_q.dir;
      end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    st_d.irqStat = (st_q.irqStat & ~w1c) | events;
    st_d.irq     = |(st_d.irqStat & st_d.irqMask);
  end

  // State register; polarity comes up active high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.dir      <= GOI_RST_DIR;
      st_q.level    <= GOI_RST_LEVEL;
      st_q.saved    <= GOI_RST_LEVEL;
      st_q.pol      <= GOI_RST_POL;
      st_q.irqMask  <= GOI_RST_MASK;
      st_q.waitReq  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign readdata    = st_q.rdata;
  assign waitrequest = st_q.waitReq;
  assign gpioOut     = st_q.level;
  assign gpioOe      = st_q.dir;
  assign occupied    = st_q.occupied;
  assign irq         = st_q.irq;

endmodule : goi_top

//--- verification/goi_top_monitor.sv
// Checker of bus answer, pin and occupancy timing at the top ports
`timescale 1ns/10ps
module goi_top_monitor
  import goi_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = GOI_SEC_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  input wire logic [3:0]  gpioOut,
  input wire logic [3:0]  gpioOe,
  input wire logic        occSenseIn,
  input wire logic        occupied
);
  logic        commit;  // Full-word write taking effect now
  logic        polWr;   // Polarity write
  logic        tOk;     // Timed request in range
  logic        tBad;    // Timed request refused
  logic [7:0]  secs;    // Requested seconds
  logic        pol_q;   // Shadow of the polarity
  logic        prev_q;  // Sensor level one edge ago
  logic [1:0]  calm_q;  // Edges since sensor or polarity moved
  logic [31:0] left_q;  // Edges the timed level must still show
  logic [1:0]  tPin_q;  // Pin under the timed request
  logic        tLvl_q;  // Requested level
  logic        tSave_q; // Level due back after expiry
  assign commit = write && !waitrequest && byteenable == 4'hF;
  assign secs   = writedata[23:16];
  assign polWr  = commit && address == GOI_OFS_OCC_CTRL;
  assign tOk    = commit && address == GOI_OFS_TIMED &&
                  secs >= GOI_TIME_MIN_S && secs <= GOI_TIME_MAX_S;
  assign tBad   = commit && address == GOI_OFS_TIMED && !tOk;
  // Shadows; only one timed request at a time is tracked, a limitation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_q   <= 1'b1;
      prev_q  <= 1'b0;
      calm_q  <= 2'h0;
      left_q  <= 32'h0;
      tPin_q  <= 2'h0;
      tLvl_q  <= 1'b0;
      tSave_q <= 1'b0;
    end else begin
      prev_q <= occSenseIn;
      if (polWr) pol_q <= writedata[0];
      // Settling margin beats the two-stage sampler, so no race
      if (polWr || occSenseIn != prev_q) calm_q <= 2'h0;
      else if (calm_q != 2'h3) calm_q <= calm_q + 2'h1;
      if (tOk) begin
        left_q  <= secs * SEC_CYCLES + 32'h1;
        tPin_q  <= writedata[1:0];
        tLvl_q  <= writedata[8];
        tSave_q <= gpioOut[writedata[1:0]];
      end else if (commit && address == GOI_OFS_TOGGLE &&
                   writedata[tPin_q]) begin
        left_q <= 32'h0; // Toggle ends the timed level early
      end else if (left_q != 32'h0) begin
        left_q <= left_q - 32'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("bus answer late");
  property p_dir; commit && address == GOI_OFS_DIR |=>
    gpioOe == $past(writedata[3:0]); endproperty
  a_dir: assert property (p_dir) else $error("direction lost");
  property p_lvl; commit && address == GOI_OFS_LEVEL && left_q == 32'h0
    |=> gpioOut == $past(writedata[3:0]); endproperty
  a_lvl: assert property (p_lvl) else $error("level lost");
  property p_tog; commit && address == GOI_OFS_TOGGLE |=>
    gpioOut == ($past(gpioOut) ^ $past(writedata[3:0])); endproperty
  a_tog: assert property (p_tog) else $error("toggle wrong");
  property p_occ; calm_q == 2'h3 |-> occupied == (occSenseIn == pol_q);
  endproperty
  a_occ: assert property (p_occ) else $error("occupancy wrong");
  property p_hold; left_q != 32'h0 |-> gpioOut[tPin_q] == tLvl_q; endproperty
  a_hold: assert property (p_hold) else $error("timed level lost");
  property p_back; left_q == 32'h1 |=> gpioOut[tPin_q] == tSave_q; endproperty
  a_back: assert property (p_back) else $error("level not restored");
  property p_rej; tBad |=> $stable(gpioOut); endproperty
  a_rej: assert property (p_rej) else $error("bad time accepted");
endmodule : goi_top_monitor

bind goi_top goi_top_monitor #(.SEC_CYCLES(SEC_CYCLES)) i_mon (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .gpioOut(gpioOut), .gpioOe(gpioOe),
  .occSenseIn(occSenseIn), .occupied(occupied));

//--- verification/goi_pin_partner.sv
// Model of the equipment and sensor wired to the block pins
`timescale 1ns/10ps
module goi_pin_partner
  import goi_pkg::*;
(
  input  wire logic [GOI_PIN_COUNT-1:0] gpioOut,
  input  wire logic [GOI_PIN_COUNT-1:0] gpioOe,
  input  wire logic [GOI_PIN_COUNT-1:0] extLevel,
  input  wire logic                     occLevel,
  output logic [GOI_PIN_COUNT-1:0]      gpioIn,
  output logic                          occSenseIn
);
  // Wire level: the block wins where it drives, else the equipment
  always_comb begin
    for (int i = 0; i < GOI_PIN_COUNT; i++) begin
      gpioIn[i] = gpioOe[i] ? gpioOut[i] : extLevel[i];
    end
  end
  // Sensor contact passes its level straight to the pin
  assign occSenseIn = occLevel;
endmodule : goi_pin_partner

//--- verification/gpio_and_occupancy_input_bench.sv
// Self-checking bench of the pin and occupancy block
`timescale 1ns/10ps
module gpio_and_occupancy_input_bench;
  import goi_pkg::*;
  localparam int unsigned SC = 10; // Short second keeps 120 s brief
  // One ordinary case: write, read back, expected pins
  typedef struct packed {
    logic [5:0]  adr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [3:0]  out;
    logic [3:0]  oe;
  } goi_row_t;
  localparam goi_row_t ROWS [9] = '{
    '{GOI_OFS_DIR, 32'h5, 32'h5, 4'h0, 4'h5},
    '{GOI_OFS_LEVEL, 32'hA, 32'hA, 4'hA, 4'h5},
    '{GOI_OFS_TOGGLE, 32'h3, 32'h0, 4'h9, 4'h5},
    '{GOI_OFS_TOGGLE, 32'hF, 32'h0, 4'h6, 4'h5},
    '{GOI_OFS_DIR, 32'hF, 32'hF, 4'h6, 4'hF},
    '{GOI_OFS_PIN_IN, 32'h0, 32'h6, 4'h6, 4'hF},
    '{GOI_OFS_TSTAT, 32'hF, 32'h0, 4'h6, 4'hF},
    '{GOI_OFS_IRQ_MASK, 32'h7, 32'h7, 4'h6, 4'hF},
    '{6'h3C, 32'hFFFF_FFFF, 32'h0, 4'h6, 4'hF}};
  localparam logic [31:0] BAD [2] = '{32'h0000_0101, 32'h0079_0101};
  localparam logic [7:0]  GOOD [2] = '{8'h01, 8'h78};
  localparam logic [37:0] RST [5] = '{{GOI_OFS_DIR, 32'h0},
    {GOI_OFS_LEVEL, 32'h0}, {GOI_OFS_OCC_CTRL, 32'h1},
    {GOI_OFS_IRQ_MASK, 32'h0}, {GOI_OFS_PIN_IN, 32'hC}};
  logic        clk, rst_n, read, write, waitrequest;
  logic        occSenseIn, occupied, irq, occLevel;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, rdv;
  logic [3:0]  byteenable, gpioIn, gpioOut, gpioOe, extLevel;
  int          fails, nChecks, cyc;
  goi_top #(.SEC_CYCLES(SC)) i_dut (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .occSenseIn(occSenseIn),
    .occupied(occupied), .irq(irq));
  goi_pin_partner i_far (.gpioOut(gpioOut), .gpioOe(gpioOe),
    .extLevel(extLevel), .occLevel(occLevel), .gpioIn(gpioIn),
    .occSenseIn(occSenseIn));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Mismatch counter and report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One access; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rdv = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Hang guard, well above the longest timed wait
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'hF; // Full words only
    extLevel = 4'hC;
    occLevel = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].adr, ROWS[i].wd);
      bus(1'b0, ROWS[i].adr, 32'h0);
      check(rdv, ROWS[i].rd);
      check({28'h0, gpioOut}, {28'h0, ROWS[i].out});
      check({28'h0, gpioOe}, {28'h0, ROWS[i].oe});
    end
    $display("test rows done");
    // Every polarity against every sensed level
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        bus(1'b1, GOI_OFS_OCC_CTRL, 32'(p));
        occLevel <= l[0];
        repeat (4) @(posedge clk);
        bus(1'b0, GOI_OFS_OCC_STAT, 32'h0);
        check(rdv, {30'h0, l[0] == p[0], l[0]});
        check({31'h0, occupied}, {31'h0, l[0] == p[0]});
      end
    end
    check({31'h0, irq}, 32'h1);
    bus(1'b1, GOI_OFS_IRQ_MASK, 32'h0);
    bus(1'b0, GOI_OFS_IRQ_STAT, 32'h0);
    check(rdv, 32'h4);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, GOI_OFS_IRQ_STAT, 32'h7);
    bus(1'b1, GOI_OFS_IRQ_MASK, 32'h2);
    bus(1'b1, GOI_OFS_LEVEL, 32'h0);
    $display("test occupancy done");
    // Zero and 121 seconds are refused
    foreach (BAD[i]) begin
      bus(1'b1, GOI_OFS_TIMED, BAD[i]);
      bus(1'b0, GOI_OFS_IRQ_STAT, 32'h0);
      check(rdv, 32'h2);
      check({28'h0, gpioOut}, 32'h0);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, GOI_OFS_IRQ_STAT, 32'h2);
    end
    // Both ends of the range, exact to the cycle
    foreach (GOOD[i]) begin
      bus(1'b1, GOI_OFS_TIMED, {8'h00, GOOD[i], 16'h0102});
      @(posedge clk);
      check({28'h0, gpioOut}, 32'h4);
      repeat (GOOD[i] * SC) @(posedge clk);
      check({28'h0, gpioOut}, 32'h4);
      @(posedge clk);
      check({28'h0, gpioOut}, 32'h0);
      bus(1'b0, GOI_OFS_IRQ_STAT, 32'h0);
      check(rdv, 32'h1);
      bus(1'b1, GOI_OFS_IRQ_STAT, 32'h1);
    end
    // Level write under a timer, then toggle cancels the timer
    bus(1'b1, GOI_OFS_TIMED, 32'h0005_0101);
    bus(1'b1, GOI_OFS_LEVEL, 32'h2);
    bus(1'b0, GOI_OFS_TSTAT, 32'h0);
    check(rdv, 32'h2);
    check({28'h0, gpioOut}, 32'h2);
    bus(1'b1, GOI_OFS_TOGGLE, 32'h2);
    bus(1'b0, GOI_OFS_TSTAT, 32'h0);
    check(rdv, 32'h0);
    check({28'h0, gpioOut}, 32'h0);
    repeat (60) @(posedge clk);
    check({28'h0, gpioOut}, 32'h0);
    $display("test timed done");
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (RST[i]) begin
      bus(1'b0, RST[i][37:32], 32'h0);
      check(rdv, RST[i][31:0]);
    end
    check({23'h0, gpioOut, gpioOe, occupied}, 32'h1);
    $display("test reset done");
    wrap_up();
  end
endmodule : gpio_and_occupancy_input_bench
